//--- microcoded_timer_table.sv
// timer table engine with command register handshake and host register port
// Contract
// - Pending flag is 1 while a command runs, 0 when done or after reset.
// - Writing the full-reset value clears the command register within two clocks.
// - Command register keeps written value while running, then only the flag clears.
// - Commands finish within 120 clocks, typically about 40.
// - Up to 16 table timers paced by a private tick.
// - Each timer is one-shot or restart; expiry can raise a maskable interrupt.
// - Tick is a programmable multiple of 1024 clocks from the tick configuration.
// - Table scanning has lowest priority; busy intervals may skip a tick.
// - Parameter area: base, pointer, mode, valid words, command long, tick count long.
// - Scan pointer is kept by the engine only and is read-only.
// - One mode bit per timer, changed only by the arm command or a full reset.
// - One valid bit per timer, changed only by command execution, scanning or a full reset.
// - Bits 15 to 0 give the period; zero means 65536 ticks.
// - Tick count advances once per serviced tick, written after the scan.
// - Each entry holds an initial word and a decrementing current word.
// - Valid timers decrement; timeout sets event, restart reloads, one-shot invalidates.
// - Event bits clear on writing one; zero leaves them; several at once.
// - Arm command updates the table at once; scanning waits for the next tick.
`timescale 1ns/1ps
`include "timer_table_regs.svh"
module microcoded_timer_table #(
	parameter int NUM_TIMERS = 16,
	parameter int CMD_CLK = `TT_CMD_TYP_CLK,
	parameter int TICK_UNIT = `TT_TICK_UNIT_CLK
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [7:0] addr_i,
	input wire logic wr_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rd_data_o,
	output logic irq_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] table_base_offset;
		logic [3:0] table_scan_pointer;
		logic [15:0] timer_mode_bits;
		logic [15:0] timer_valid_bits;
		logic [31:0] timer_command_param;
		logic [31:0] elapsed_tick_count;
		logic [15:0] command_register;
		logic [15:0] timer_event_register;
		logic [15:0] timer_mask_register;
		logic [15:0] tick_config_register;
		logic [15:0][15:0] init_val;
		logic [15:0][15:0] cur_val;
		timer_table_pkg::cmd_state_t cmd;
		logic [6:0] lat;
		timer_table_pkg::scan_state_t scan;
		logic tick_pend;
		logic [15:0] rd_data;
		logic irq;
	} table_state_t;

	table_state_t state_ff;
	table_state_t nxt_state;
	logic tick_w;
	logic step_valid;
	logic step_exp;
	logic [15:0] step_cur;
	logic [15:0] ev_set;
	logic [15:0] ev_clr;
	logic [15:0] rd_mux;
	logic cr_wr;
	logic full_rst;
	logic scan_go;
	logic [3:0] arm_num;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a[7:1] == ofs[7:1];
	endfunction

	function automatic logic is_set_timer(input logic [15:0] cr);
		return cr[`TT_CR_OP_RANGE] == `TT_OP_SET_TIMER && cr[`TT_CR_CH_RANGE] == `TT_CH_TIMERS;
	endfunction

	// ----------------------------------------------------------------
	// tick source and entry datapath
	// ----------------------------------------------------------------
	tick_gen #(
		.UNIT(TICK_UNIT)
	) u_tick (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.en_i(state_ff.tick_config_register[`TT_TCFG_EN]),
		.mult_i(state_ff.tick_config_register[`TT_TCFG_MULT_RANGE]),
		.tick_o(tick_w)
	);

	timer_step u_step (
		.valid_i(state_ff.timer_valid_bits[state_ff.table_scan_pointer]),
		.restart_i(state_ff.timer_mode_bits[state_ff.table_scan_pointer]),
		.init_i(state_ff.init_val[state_ff.table_scan_pointer]),
		.cur_i(state_ff.cur_val[state_ff.table_scan_pointer]),
		.cur_o(step_cur),
		.valid_o(step_valid),
		.expire_o(step_exp)
	);

	assign cr_wr = wr_i && hit(addr_i, `TT_OFS_CR);
	assign full_rst = cr_wr && wdata_i[`TT_CR_RST];
	assign arm_num = state_ff.timer_command_param[`TT_CMDP_NUM_RANGE];
	// scanning yields to command execution
	assign scan_go = state_ff.scan == timer_table_pkg::SCAN_RUN
		&& state_ff.cmd == timer_table_pkg::CMD_IDLE;

	// ----------------------------------------------------------------
	// read multiplexer
	// ----------------------------------------------------------------
	always_comb begin
		rd_mux = `TT_RST_WORD;
		if (addr_i[7:6] == `TT_ENTRY_REGION) begin
			rd_mux = addr_i[1] ? state_ff.cur_val[addr_i[5:2]]
				: state_ff.init_val[addr_i[5:2]];
		end else if (hit(addr_i, `TT_OFS_BASE)) begin
			rd_mux = state_ff.table_base_offset;
		end else if (hit(addr_i, `TT_OFS_PTR)) begin
			rd_mux = state_ff.table_base_offset + {10'h000, state_ff.table_scan_pointer, 2'h0};
		end else if (hit(addr_i, `TT_OFS_MODE)) begin
			rd_mux = state_ff.timer_mode_bits;
		end else if (hit(addr_i, `TT_OFS_VALID)) begin
			rd_mux = state_ff.timer_valid_bits;
		end else if (hit(addr_i, `TT_OFS_CMDP_HI)) begin
			rd_mux = state_ff.timer_command_param[31:16];
		end else if (hit(addr_i, `TT_OFS_CMDP_LO)) begin
			rd_mux = state_ff.timer_command_param[15:0];
		end else if (hit(addr_i, `TT_OFS_CNT_HI)) begin
			rd_mux = state_ff.elapsed_tick_count[31:16];
		end else if (hit(addr_i, `TT_OFS_CNT_LO)) begin
			rd_mux = state_ff.elapsed_tick_count[15:0];
		end else if (hit(addr_i, `TT_OFS_CR)) begin
			rd_mux = state_ff.command_register;
		end else if (hit(addr_i, `TT_OFS_EVT)) begin
			rd_mux = state_ff.timer_event_register;
		end else if (hit(addr_i, `TT_OFS_MASK)) begin
			rd_mux = state_ff.timer_mask_register;
		end else if (hit(addr_i, `TT_OFS_TCFG)) begin
			rd_mux = state_ff.tick_config_register;
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		ev_set = 16'h0000;
		ev_clr = 16'h0000;
		// host writes; pointer, mode, valid and entries are read-only
		if (wr_i) begin
			if (hit(addr_i, `TT_OFS_BASE)) begin
				nxt_state.table_base_offset = wdata_i;
			end
			if (hit(addr_i, `TT_OFS_CMDP_HI)) begin
				nxt_state.timer_command_param[31:16] = wdata_i;
			end
			if (hit(addr_i, `TT_OFS_CMDP_LO)) begin
				nxt_state.timer_command_param[15:0] = wdata_i;
			end
			if (hit(addr_i, `TT_OFS_CNT_HI)) begin
				nxt_state.elapsed_tick_count[31:16] = wdata_i;
			end
			if (hit(addr_i, `TT_OFS_CNT_LO)) begin
				nxt_state.elapsed_tick_count[15:0] = wdata_i;
			end
			if (hit(addr_i, `TT_OFS_EVT)) begin
				ev_clr = wdata_i;
			end
			if (hit(addr_i, `TT_OFS_MASK)) begin
				nxt_state.timer_mask_register = wdata_i;
			end
			if (hit(addr_i, `TT_OFS_TCFG)) begin
				nxt_state.tick_config_register = wdata_i;
			end
		end
		// command handshake
		unique case (state_ff.cmd)
			timer_table_pkg::CMD_IDLE: begin
				if (cr_wr && !wdata_i[`TT_CR_RST]) begin
					nxt_state.command_register = wdata_i;
					if (wdata_i[`TT_CR_FLG]) begin
						nxt_state.cmd = timer_table_pkg::CMD_EXEC;
						nxt_state.lat = 7'h00;
					end
				end
			end
			timer_table_pkg::CMD_EXEC: begin
				// further non-reset writes are ignored until the flag clears
				nxt_state.lat = state_ff.lat + 7'h01;
				if (state_ff.lat == 7'(CMD_CLK - 1)) begin
					nxt_state.cmd = timer_table_pkg::CMD_IDLE;
					nxt_state.command_register[`TT_CR_FLG] = 1'b0;
					if (is_set_timer(state_ff.command_register)) begin
						if (state_ff.timer_command_param[`TT_CMDP_V]) begin
							nxt_state.timer_valid_bits[arm_num] = 1'b1;
							nxt_state.timer_mode_bits[arm_num] =
								state_ff.timer_command_param[`TT_CMDP_R];
							nxt_state.init_val[arm_num] =
								state_ff.timer_command_param[`TT_CMDP_PER_RANGE];
							nxt_state.cur_val[arm_num] =
								state_ff.timer_command_param[`TT_CMDP_PER_RANGE];
						end else begin
							nxt_state.timer_valid_bits[arm_num] = 1'b0;
						end
					end
				end
			end
		endcase
		// table scan, one entry per clock, started only by a tick
		if (scan_go) begin
			nxt_state.cur_val[state_ff.table_scan_pointer] = step_cur;
			nxt_state.timer_valid_bits[state_ff.table_scan_pointer] = step_valid;
			ev_set[state_ff.table_scan_pointer] = step_exp;
			if (state_ff.table_scan_pointer == 4'(NUM_TIMERS - 1)) begin
				nxt_state.scan = timer_table_pkg::SCAN_IDLE;
				nxt_state.table_scan_pointer = 4'h0;
				nxt_state.elapsed_tick_count = state_ff.elapsed_tick_count + 32'h0000_0001;
			end else begin
				nxt_state.table_scan_pointer = state_ff.table_scan_pointer + 4'h1;
			end
		end else if (state_ff.scan == timer_table_pkg::SCAN_IDLE && state_ff.tick_pend
			&& state_ff.cmd == timer_table_pkg::CMD_IDLE) begin
			nxt_state.scan = timer_table_pkg::SCAN_RUN;
			nxt_state.table_scan_pointer = 4'h0;
			nxt_state.tick_pend = 1'b0;
		end
		// a tick that finds the scan busy or already owed is dropped
		if (tick_w && state_ff.scan == timer_table_pkg::SCAN_IDLE && !state_ff.tick_pend) begin
			nxt_state.tick_pend = 1'b1;
		end
		// set wins over clear
		nxt_state.timer_event_register = (state_ff.timer_event_register & ~ev_clr) | ev_set;
		nxt_state.irq = |(state_ff.timer_event_register & state_ff.timer_mask_register);
		nxt_state.rd_data = rd_mux;
		// full reset of the engine and its table
		if (full_rst) begin
			nxt_state.command_register = `TT_RST_WORD;
			nxt_state.cmd = timer_table_pkg::CMD_IDLE;
			nxt_state.lat = 7'h00;
			nxt_state.scan = timer_table_pkg::SCAN_IDLE;
			nxt_state.table_scan_pointer = 4'h0;
			nxt_state.tick_pend = 1'b0;
			nxt_state.timer_valid_bits = `TT_RST_WORD;
			nxt_state.timer_mode_bits = `TT_RST_WORD;
			nxt_state.init_val = '0;
			nxt_state.cur_val = '0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			state_ff <= '0;
		end else if (ce_i) begin
			state_ff <= nxt_state;
		end
	end

	assign rd_data_o = state_ff.rd_data;
	assign irq_o = state_ff.irq;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i iff ce_i); endclocking
	default disable iff (!rst_n_i);

	sequence full_rst_s;
		cr_wr && wdata_i[`TT_CR_RST];
	endsequence

	sequence exec_start_s;
		$rose(state_ff.cmd == timer_table_pkg::CMD_EXEC);
	endsequence

	rst_cmd_clear_a: assert property (full_rst_s |-> ##[1:2] state_ff.command_register == 16'h0000)
		else $error("full reset left command register set");
	exec_bound_a: assert property (exec_start_s |-> ##[1:120] !state_ff.command_register[0])
		else $error("command did not finish in time");
	pending_flag_a: assert property (state_ff.cmd == timer_table_pkg::CMD_EXEC |-> state_ff.command_register[0])
		else $error("pending flag low during execution");
	cr_hold_a: assert property (state_ff.cmd == timer_table_pkg::CMD_EXEC ##1 state_ff.cmd == timer_table_pkg::CMD_EXEC |-> $stable(state_ff.command_register))
		else $error("command register changed while running");
	cr_done_value_a: assert property ($fell(state_ff.cmd == timer_table_pkg::CMD_EXEC) && state_ff.command_register != 16'h0000 |-> state_ff.command_register == ($past(state_ff.command_register) & 16'hfffe))
		else $error("completion changed more than the flag");
	irq_mask_a: assert property (1'b1 |=> irq_o == $past(|(state_ff.timer_event_register & state_ff.timer_mask_register)))
		else $error("interrupt does not follow masked events");
	evt_clear_a: assert property (wr_i && hit(addr_i, `TT_OFS_EVT) && wdata_i[0] && !(scan_go && step_exp && state_ff.table_scan_pointer == 4'h0) |=> !state_ff.timer_event_register[0])
		else $error("event bit not cleared by one");
	cnt_adv_a: assert property (scan_go && state_ff.table_scan_pointer == 4'(NUM_TIMERS - 1) |=> state_ff.elapsed_tick_count == $past(state_ff.elapsed_tick_count) + 32'h0000_0001)
		else $error("tick count did not advance after scan");
	oneshot_end_a: assert property (scan_go && step_exp && !state_ff.timer_mode_bits[state_ff.table_scan_pointer] && !full_rst |=> state_ff.timer_valid_bits == ($past(state_ff.timer_valid_bits) & ~(16'h0001 << $past(state_ff.table_scan_pointer))))
		else $error("one-shot timer stayed valid");
	exec_stall_a: assert property (state_ff.cmd == timer_table_pkg::CMD_EXEC && !full_rst |=> $stable(state_ff.table_scan_pointer))
		else $error("scan advanced during a command");
endmodule

//--- timer_table_regs.svh
// register offsets, field positions, reset values and timing counts of the timer table
`ifndef TIMER_TABLE_REGS_SVH
`define TIMER_TABLE_REGS_SVH
`define TT_OFS_BASE 8'h00
`define TT_OFS_PTR 8'h02
`define TT_OFS_MODE 8'h04
`define TT_OFS_VALID 8'h06
`define TT_OFS_CMDP_HI 8'h08
`define TT_OFS_CMDP_LO 8'h0a
`define TT_OFS_CNT_HI 8'h0c
`define TT_OFS_CNT_LO 8'h0e
`define TT_OFS_CR 8'h10
`define TT_OFS_EVT 8'h12
`define TT_OFS_MASK 8'h14
`define TT_OFS_TCFG 8'h16
`define TT_ENTRY_REGION 2'h1
`define TT_CR_RST 15
`define TT_CR_FLG 0
`define TT_CR_OP_RANGE 11:8
`define TT_CR_CH_RANGE 7:4
`define TT_OP_SET_TIMER 4'h8
`define TT_CH_TIMERS 4'h5
`define TT_CMDP_V 31
`define TT_CMDP_R 30
`define TT_CMDP_NUM_RANGE 19:16
`define TT_CMDP_PER_RANGE 15:0
`define TT_TCFG_EN 8
`define TT_TCFG_MULT_RANGE 5:0
`define TT_RST_WORD 16'h0000
`define TT_CMD_TYP_CLK 40
`define TT_CMD_MAX_CLK 120
`define TT_TICK_UNIT_CLK 1024
`endif

//--- timer_table_pkg.sv
// shared state types of the timer table
package timer_table_pkg;
	typedef enum logic {CMD_IDLE, CMD_EXEC} cmd_state_t;
	typedef enum logic {SCAN_IDLE, SCAN_RUN} scan_state_t;
endpackage

//--- tick_gen.sv
// tick generator: one pulse every unit times (multiplier plus one) clocks
`timescale 1ns/1ps
`include "timer_table_regs.svh"
module tick_gen #(
	parameter int UNIT = `TT_TICK_UNIT_CLK
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic en_i,
	input wire logic [5:0] mult_i,
	output logic tick_o
);
	localparam int PW = $clog2(UNIT);
	typedef struct packed {
		logic [PW-1:0] pre;
		logic [5:0] mul;
		logic tick;
	} tick_state_t;
	tick_state_t tick_ff;
	tick_state_t nxt_tick;

	always_comb begin
		nxt_tick = tick_ff;
		nxt_tick.tick = 1'b0;
		if (!en_i) begin
			nxt_tick.pre = '0;
			nxt_tick.mul = 6'h00;
		end else if (tick_ff.pre == PW'(UNIT - 1)) begin
			nxt_tick.pre = '0;
			if (tick_ff.mul >= mult_i) begin
				nxt_tick.mul = 6'h00;
				nxt_tick.tick = 1'b1;
			end else begin
				nxt_tick.mul = tick_ff.mul + 6'h01;
			end
		end else begin
			nxt_tick.pre = tick_ff.pre + PW'(1);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			tick_ff <= '0;
		end else if (ce_i) begin
			tick_ff <= nxt_tick;
		end
	end

	assign tick_o = tick_ff.tick;
endmodule

//--- timer_step.sv
// one table entry visit: decrement, expiry test and reload
`timescale 1ns/1ps
module timer_step (
	input wire logic valid_i,
	input wire logic restart_i,
	input wire logic [15:0] init_i,
	input wire logic [15:0] cur_i,
	output logic [15:0] cur_o,
	output logic valid_o,
	output logic expire_o
);
	always_comb begin
		cur_o = cur_i;
		valid_o = valid_i;
		expire_o = 1'b0;
		if (valid_i) begin
			// a loaded zero wraps first, giving the full 65536 ticks
			cur_o = cur_i - 16'h0001;
			if (cur_i == 16'h0001) begin
				expire_o = 1'b1;
				if (restart_i) begin
					cur_o = init_i;
				end else begin
					valid_o = 1'b0;
				end
			end
		end
	end
endmodule

//--- host_model.sv
// host processor model: register bus master issuing commands to the timer table
`timescale 1ns/1ps
`include "timer_table_regs.svh"
module host_model (
	input wire logic ref_clk_i,
	input wire logic [15:0] rd_data_i,
	output logic [7:0] addr_o,
	output logic wr_o,
	output logic [15:0] wdata_o
);
	initial begin
		addr_o = 8'h00;
		wr_o = 1'b0;
		wdata_o = 16'h0000;
	end

	// single-edge write strobe; entry words are never written
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge ref_clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge ref_clk_i);
		wr_o = 1'b0;
		wdata_o = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge ref_clk_i);
		addr_o = a;
		@(negedge ref_clk_i);
		d = rd_data_i;
	endtask

	// flag always set, next request only once it reads clear
	task automatic cmd(input logic [15:0] c, output logic [15:0] first, output int cyc);
		logic [15:0] d;
		wr(`TT_OFS_CR, c | 16'h0001);
		d = 16'h0001;
		first = 16'h0000;
		for (cyc = 0; cyc < 400 && d[`TT_CR_FLG] !== 1'b0; cyc += 2) begin
			rd(`TT_OFS_CR, d);
			if (cyc == 0)
				first = d;
		end
	endtask

	// enable, restart, zeroed reserved field, timer number
	task automatic arm(input logic v, r, input logic [3:0] n, input logic [15:0] p,
		output int cyc);
		logic [15:0] d;
		wr(`TT_OFS_CMDP_HI, {v, r, 10'h000, n});
		wr(`TT_OFS_CMDP_LO, p);
		cmd(16'h0851, d, cyc);
	endtask
endmodule

//--- tb.sv
// self-checking bench of the timer table engine
`timescale 1ns/1ps
`include "timer_table_regs.svh"
module tb;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] addr;
	logic wr;
	logic [15:0] wdata;
	logic [15:0] rd_data;
	logic irq;
	int mismatches = 0;
	int checked = 0;
	int clk_n = 0;
	logic [31:0] seed = 32'h4e1e_5022;

	always #12.5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) clk_n++;

	host_model u_host (.ref_clk_i(ref_clk_i), .rd_data_i(rd_data), .addr_o(addr),
		.wr_o(wr), .wdata_o(wdata));
	microcoded_timer_table #(.NUM_TIMERS(16), .CMD_CLK(40), .TICK_UNIT(4)) u_dut (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .addr_i(addr),
		.wr_i(wr), .wdata_i(wdata), .rd_data_o(rd_data), .irq_o(irq));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [15:0] bit_of(input logic [3:0] n);
		return 16'h0001 << n;
	endfunction

	function automatic logic [7:0] entry(input logic [3:0] n, input logic cur);
		return 8'h40 + {2'h0, n, 2'h0} + {6'h00, cur, 1'b0};
	endfunction

	task automatic chk(input string what, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rc(input string what, input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		u_host.rd(a, d);
		chk(what, d, e);
	endtask

	task automatic wait_cnt(input logic [15:0] t);
		logic [15:0] d;
		d = 16'hffff;
		for (int i = 0; i < 200 && d !== t; i++)
			u_host.rd(`TT_OFS_CNT_LO, d);
		chk("ticks", d, t);
	endtask

	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge ref_clk_i);
		mismatches++;
		tally_and_finish();
	end

	initial begin
		logic [15:0] d;
		logic [15:0] base;
		logic [15:0] per;
		logic [3:0] n;
		logic r;
		int cyc;
		int t0;
		repeat (12) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		rst_n_i = 1'b1;
		rc("cr", `TT_OFS_CR, 16'h0000);
		rc("ticks", `TT_OFS_CNT_LO, 16'h0000);
		// read-only words ignore writes, unmapped space reads zero
		base = 16'(rnd()) & 16'hfffc;
		u_host.wr(`TT_OFS_BASE, base); // long-word aligned offset
		u_host.wr(`TT_OFS_PTR, 16'h1234);
		u_host.wr(`TT_OFS_VALID, 16'hffff);
		u_host.wr(`TT_OFS_MODE, 16'hffff);
		u_host.wr(8'h30, 16'hffff);
		rc("base", `TT_OFS_BASE, base);
		rc("pointer", `TT_OFS_PTR, base);
		rc("valid", `TT_OFS_VALID, 16'h0000);
		rc("mode", `TT_OFS_MODE, 16'h0000);
		rc("unmapped", 8'h30, 16'h0000);
		// non-timer command: flag held while running
		u_host.cmd(16'h0381, d, cyc);
		chk("cr busy", d, 16'h0381);
		rc("cr done", `TT_OFS_CR, 16'h0380);
		chk("latency", 16'(cyc >= 40 && cyc <= 121), 16'h0001);
		for (int k = 0; k < 4; k++) begin
			n = (k == 0) ? 4'hf : 4'(rnd());
			per = (k == 1) ? 16'h0001 : 16'(rnd() % 3 + 1);
			r = (k < 2) ? 1'(k) : 1'(rnd());
			u_host.wr(`TT_OFS_TCFG, 16'h0000);
			u_host.wr(`TT_OFS_CNT_HI, 16'h0000);
			u_host.wr(`TT_OFS_CNT_LO, 16'h0000);
			u_host.wr(`TT_OFS_EVT, 16'hffff);
			u_host.wr(`TT_OFS_MASK, bit_of(n));
			u_host.arm(1'b1, r, n, per, cyc);
			chk("arm latency", 16'(cyc <= 121), 16'h0001);
			rc("valid", `TT_OFS_VALID, bit_of(n));
			rc("mode", `TT_OFS_MODE, r ? bit_of(n) : 16'h0000);
			rc("init", entry(n, 1'b0), per);
			rc("cur", entry(n, 1'b1), per);
			// tick every 4 * (7 + 1) clocks
			u_host.wr(`TT_OFS_TCFG, 16'h0107);
			wait_cnt(per - 16'h0001);
			t0 = clk_n;
			rc("evt early", `TT_OFS_EVT, 16'h0000);
			chk("irq early", {15'h0000, irq}, 16'h0000);
			wait_cnt(per);
			u_host.wr(`TT_OFS_TCFG, 16'h0000);
			if (per > 16'h0001)
				chk("tick span", 16'(clk_n - t0 >= 30 && clk_n - t0 <= 40), 16'h0001);
			rc("evt", `TT_OFS_EVT, bit_of(n));
			chk("irq", {15'h0000, irq}, 16'h0001);
			rc("valid after", `TT_OFS_VALID, r ? bit_of(n) : 16'h0000);
			if (r)
				rc("reload", entry(n, 1'b1), per);
			u_host.wr(`TT_OFS_EVT, ~bit_of(n));
			rc("evt kept", `TT_OFS_EVT, bit_of(n));
			u_host.wr(`TT_OFS_MASK, 16'h0000);
			rc("mask", `TT_OFS_MASK, 16'h0000);
			chk("irq masked", {15'h0000, irq}, 16'h0000);
			u_host.wr(`TT_OFS_EVT, 16'hffff);
			rc("evt clear", `TT_OFS_EVT, 16'h0000);
			u_host.arm(1'b0, 1'b0, n, 16'h0000, cyc);
			rc("disarm", `TT_OFS_VALID, 16'h0000);
			u_host.arm(1'b1, 1'b1, n, per, cyc);
			u_host.wr(`TT_OFS_CR, 16'h8001);
			rc("cr reset", `TT_OFS_CR, 16'h0000);
			rc("valid reset", `TT_OFS_VALID, 16'h0000);
		end
		tally_and_finish();
	end
endmodule
